// ==== hdl/mvx_exec.sv ====
// Purpose: executes the move, store, load-literal and no-op instructions
// Assumes: one instruction word per valid cycle from program memory
// Notes:   two-stage, one instruction retired per cycle
// Behaviour
// [RQ1] file move with dest 0 loads working
// [RQ2] file move with dest 1 rewrites file
// [RQ3] file move sets zero from moved value
// [RQ4] store copies working to file, flags kept
// [RQ5] literal loads working, flags kept
// [RQ6] producer zeroes literal don't-care bits
// [RQ7] no-op changes nothing; one word, one cycle
`include "mvx_regs.svh"

module mvx_exec (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // instruction stream
  input  wire logic                     instr_valid,
  input  wire logic [`MVX_WORD_W-1:0]   instr_word,
  // file register observation
  input  wire logic [`MVX_ADDR_W-1:0]   peek_addr,
  output      logic [`MVX_DATA_W-1:0]   peek_data,
  // core state
  output      logic [`MVX_DATA_W-1:0]   work_reg,
  output      logic                     zero_flag,
  output      logic                     retire,
  output      logic                     unsupported
);

  // ==========================================================
  // decode
  function automatic mvx_pkg::mvx_op_type decode_op(input logic [`MVX_WORD_W-1:0] w);
    if ((w & `MVX_FILE_MASK) == `MVX_FILE_MATCH) begin
      return mvx_pkg::MVX_OP_MOVE_FROM_FILE_INSTR;
    end else if ((w & `MVX_STORE_MASK) == `MVX_STORE_MATCH) begin
      return mvx_pkg::MVX_OP_STORE_WORKING_INSTR;
    end else if ((w & `MVX_LIT_MASK) == `MVX_LIT_MATCH) begin
      return mvx_pkg::MVX_OP_LOAD_LITERAL_INSTR;
    end else if ((w & `MVX_NOP_MASK) == `MVX_NOP_MATCH) begin
      return mvx_pkg::MVX_OP_NO_OP_INSTR;
    end
    return mvx_pkg::MVX_OP_UNSUPPORTED;
  endfunction : decode_op

  mvx_file_if file ();

  mvx_file_mem u_mem (
    .sys_clk (sys_clk),
    .port    (file)
  );

  mvx_pkg::mvx_state_type   ex_state;
  mvx_pkg::mvx_state_type   next_state;
  mvx_pkg::mvx_op_type      ex_op;
  mvx_pkg::mvx_op_type      next_op;
  logic [`MVX_ADDR_W-1:0]   ex_addr;
  logic                     ex_dest;
  logic [`MVX_DATA_W-1:0]   ex_lit;
  logic                     last_wr_valid;
  logic [`MVX_ADDR_W-1:0]   last_wr_addr;
  logic [`MVX_DATA_W-1:0]   last_wr_data;
  wire                      is_exec;
  wire                      op_file;
  wire                      op_store;
  wire                      op_lit;
  wire                      op_nop;
  wire                      op_bad;
  wire                      fwd_hit;
  wire  [`MVX_DATA_W-1:0]   src_val;
  wire  [`MVX_DATA_W-1:0]   next_work;
  wire                      next_zero;

  assign next_op    = decode_op(instr_word);
  assign next_state = instr_valid ? mvx_pkg::MVX_ST_EXEC : mvx_pkg::MVX_ST_EMPTY; // RQ7
  assign is_exec    = (ex_state == mvx_pkg::MVX_ST_EXEC);
  assign op_file    = is_exec && (ex_op == mvx_pkg::MVX_OP_MOVE_FROM_FILE_INSTR);
  assign op_store   = is_exec && (ex_op == mvx_pkg::MVX_OP_STORE_WORKING_INSTR);
  assign op_lit     = is_exec && (ex_op == mvx_pkg::MVX_OP_LOAD_LITERAL_INSTR);
  assign op_nop     = is_exec && (ex_op == mvx_pkg::MVX_OP_NO_OP_INSTR);
  assign op_bad     = is_exec && (ex_op == mvx_pkg::MVX_OP_UNSUPPORTED);

  // ==========================================================
  // file access and forwarding
  assign file.rd_addr = instr_word[`MVX_F_ADDR_MSB:0];
  assign file.pk_addr = peek_addr;
  assign peek_data    = file.pk_data;
  assign fwd_hit      = last_wr_valid && (last_wr_addr == ex_addr);
  assign src_val      = fwd_hit ? last_wr_data : file.rd_data;
  assign file.wr_en   = (op_file && ex_dest) || op_store; // RQ2 RQ4
  assign file.wr_addr = ex_addr;
  assign file.wr_data = op_store ? work_reg : src_val; // RQ2 RQ4

  // ==========================================================
  // working register and zero flag
  assign next_work = (op_file && !ex_dest) ? src_val : // RQ1
                     op_lit ? ex_lit : work_reg; // RQ5 RQ7
  assign next_zero = op_file ? (src_val == 8'h00) : zero_flag; // RQ3 RQ4 RQ5 RQ7

  // ==========================================================
  // stage registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ex_state <= mvx_pkg::MVX_ST_EMPTY;
      ex_op    <= mvx_pkg::MVX_OP_NONE;
      ex_addr  <= 7'h00;
      ex_dest  <= 1'h0;
      ex_lit   <= 8'h00;
    end else begin
      ex_state <= next_state;
      ex_op    <= next_op;
      ex_addr  <= instr_word[`MVX_F_ADDR_MSB:0];
      ex_dest  <= instr_word[`MVX_F_DEST_BIT];
      ex_lit   <= instr_word[`MVX_F_LIT_MSB:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_wr_valid <= 1'h0;
      last_wr_addr  <= 7'h00;
      last_wr_data  <= 8'h00;
    end else begin
      last_wr_valid <= file.wr_en;
      last_wr_addr  <= file.wr_addr;
      last_wr_data  <= file.wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      work_reg    <= `MVX_WORK_RST;
      zero_flag   <= `MVX_ZERO_RST;
      retire      <= 1'h0;
      unsupported <= 1'h0;
    end else begin
      work_reg    <= next_work;
      zero_flag   <= next_zero;
      retire      <= is_exec; // RQ7
      unsupported <= op_bad;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_file_to_work;
    op_file && !ex_dest;
  endsequence

  sequence s_file_back;
    op_file && ex_dest;
  endsequence

  property p_file_to_work;
    s_file_to_work |=> (work_reg == $past(src_val));
  endproperty
  a_file_to_work: assert property (p_file_to_work) else $error("move to working wrong"); // RQ1

  property p_file_back;
    s_file_back |-> file.wr_en && (file.wr_addr == ex_addr) && (file.wr_data == src_val)
                    ##1 $stable(work_reg);
  endproperty
  a_file_back: assert property (p_file_back) else $error("write-back wrong"); // RQ2

  property p_file_zero;
    op_file |=> (zero_flag == ($past(src_val) == 8'h00));
  endproperty
  a_file_zero: assert property (p_file_zero) else $error("zero flag wrong"); // RQ3

  property p_store;
    op_store |-> (file.wr_en && file.wr_data == work_reg && file.wr_addr == ex_addr)
                 ##1 ($stable(zero_flag) && $stable(work_reg));
  endproperty
  a_store: assert property (p_store) else $error("store wrong"); // RQ4

  property p_literal;
    op_lit |=> (work_reg == $past(ex_lit)) && $stable(zero_flag);
  endproperty
  a_literal: assert property (p_literal) else $error("literal load wrong"); // RQ5

  property p_nop;
    op_nop |-> !file.wr_en ##1 ($stable(work_reg) && $stable(zero_flag));
  endproperty
  a_nop: assert property (p_nop) else $error("no-op changed state"); // RQ7

  property p_one_cycle;
    instr_valid |-> ##2 retire;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("instruction not retired"); // RQ7

  property p_forward;
    (file.wr_en ##1 (is_exec && ex_addr == $past(file.wr_addr)))
      |-> src_val == $past(file.wr_data);
  endproperty
  a_forward: assert property (p_forward) else $error("forwarding missed"); // RQ1

  sequence s_state_kept;
    $stable(work_reg) && $stable(zero_flag);
  endsequence

  property p_work_no_write;
    s_file_to_work |-> !file.wr_en;
  endproperty
  a_work_no_write: assert property (p_work_no_write) else $error("move wrote file"); // RQ1

  property p_idle;
    !is_exec |-> !file.wr_en ##1 (!retire && !unsupported) ##0 s_state_kept;
  endproperty
  a_idle: assert property (p_idle) else $error("idle cycle changed state"); // RQ7

  property p_unsupported;
    op_bad |-> !file.wr_en ##1 (retire && unsupported) ##0 s_state_kept;
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("unknown word acted"); // RQ7

  property p_flag_pair;
    unsupported |-> retire;
  endproperty
  a_flag_pair: assert property (p_flag_pair) else $error("flag without retire"); // RQ7

endmodule : mvx_exec

// ==== hdl/mvx_regs.svh ====
// Purpose: constants for the move and no-op instruction executor
// Assumes: 14-bit instruction words, 128 file registers of 8 bits
// Notes:   opcode patterns are mask and match pairs
`ifndef MVX_REGS_SVH
`define MVX_REGS_SVH

// ==========================================================
// widths and field positions
`define MVX_WORD_W        14
`define MVX_DATA_W        8
`define MVX_ADDR_W        7
`define MVX_FILE_DEPTH    128
`define MVX_F_DEST_BIT    7
`define MVX_F_ADDR_MSB    6
`define MVX_F_LIT_MSB     7

// ==========================================================
// opcode patterns
`define MVX_FILE_MASK     14'h3F00
`define MVX_FILE_MATCH    14'h0800
`define MVX_STORE_MASK    14'h3F80
`define MVX_STORE_MATCH   14'h0080
`define MVX_LIT_MASK      14'h3C00
`define MVX_LIT_MATCH     14'h3000
`define MVX_NOP_MASK      14'h3F9F
`define MVX_NOP_MATCH     14'h0000

// ==========================================================
// reset values
`define MVX_WORK_RST      8'h00
`define MVX_ZERO_RST      1'h0

`endif

// ==== hdl/mvx_pkg.sv ====
// Purpose: types of the move and no-op instruction executor
// Assumes: one-hot codes throughout
// Notes:   none
package mvx_pkg;

  // ==========================================================
  // stage state
  typedef enum logic [1:0] {
    MVX_ST_EMPTY = 2'h1,
    MVX_ST_EXEC  = 2'h2
  } mvx_state_type;

  // ==========================================================
  // decoded operation
  typedef enum logic [5:0] {
    MVX_OP_NONE                 = 6'h01,
    MVX_OP_MOVE_FROM_FILE_INSTR = 6'h02,
    MVX_OP_STORE_WORKING_INSTR  = 6'h04,
    MVX_OP_LOAD_LITERAL_INSTR   = 6'h08,
    MVX_OP_NO_OP_INSTR          = 6'h10,
    MVX_OP_UNSUPPORTED          = 6'h20
  } mvx_op_type;

endpackage : mvx_pkg

// ==== hdl/mvx_file_if.sv ====
// Purpose: file register array port bundle
// Assumes: read data registered inside the memory
// Notes:   one write port, two read ports
`include "mvx_regs.svh"

interface mvx_file_if;
  logic                     wr_en;
  logic [`MVX_ADDR_W-1:0]   wr_addr;
  logic [`MVX_DATA_W-1:0]   wr_data;
  logic [`MVX_ADDR_W-1:0]   rd_addr;
  logic [`MVX_DATA_W-1:0]   rd_data;
  logic [`MVX_ADDR_W-1:0]   pk_addr;
  logic [`MVX_DATA_W-1:0]   pk_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr,
               input rd_data, output pk_addr, input pk_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr,
               output rd_data, input pk_addr, output pk_data);
endinterface : mvx_file_if

// ==== hdl/mvx_file_mem.sv ====
// Purpose: file register array, 128 words of 8 bits
// Assumes: read returns contents before a same-edge write
// Notes:   both read ports are registered
`include "mvx_regs.svh"

module mvx_file_mem (
  // clock
  input  wire logic sys_clk,
  // array port
  mvx_file_if.mem   port
);

  // ==========================================================
  // storage
  logic [`MVX_DATA_W-1:0] mem [`MVX_FILE_DEPTH];

  always_ff @(posedge sys_clk) begin
    if (port.wr_en) begin
      mem[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= mem[port.rd_addr];
    port.pk_data <= mem[port.pk_addr];
  end

endmodule : mvx_file_mem

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench for the move and no-op instruction executor
// Assumes: answer visible after the edge following the one that takes a word
// Notes:   file contents observed through the peek port
`include "mvx_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic                   sys_clk     = 1'b0;
  logic                   rst_n       = 1'b0;
  logic                   instr_valid = 1'b0;
  logic [`MVX_WORD_W-1:0] instr_word  = 14'h0000;
  logic [`MVX_ADDR_W-1:0] peek_addr   = 7'h00;
  logic [`MVX_DATA_W-1:0] peek_data;
  logic [`MVX_DATA_W-1:0] work_reg;
  logic                   zero_flag;
  logic                   retire;
  logic                   unsupported;
  int                     n_fail      = 0;
  int                     num_checks  = 0;
  int                     n_ret       = 0;
  int                     n_cyc       = 0;

  always #20 sys_clk = ~sys_clk;

  mvx_exec uut (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .instr_valid (instr_valid),
    .instr_word  (instr_word),
    .peek_addr   (peek_addr),
    .peek_data   (peek_data),
    .work_reg    (work_reg),
    .zero_flag   (zero_flag),
    .retire      (retire),
    .unsupported (unsupported)
  );

  // ==========================================================
  // retire counter and timeout
  always @(posedge sys_clk) begin
    if (retire === 1'b1) n_ret++;
    n_cyc++;
    if (n_cyc == 2000) begin
      n_fail++;
      $display("Error at %0t: timeout", $time);
      end_sim();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask : chk

  task automatic exec(input logic [13:0] w, input logic bad = 1'b0);
    instr_valid = 1'b1;
    instr_word  = w;
    @(posedge sys_clk) #1;
    instr_valid = 1'b0;
    @(posedge sys_clk) #1;
    chk({6'h00, retire, unsupported}, {6'h00, 1'b1, bad}, "retire pulse");
  endtask : exec

  task automatic state(input logic [7:0] w, input logic z);
    chk(work_reg, w, "working register");
    chk({7'h00, zero_flag}, {7'h00, z}, "zero flag");
  endtask : state

  task automatic peek(input logic [6:0] a, input logic [7:0] e);
    peek_addr = a;
    @(posedge sys_clk) #1;
    chk(peek_data, e, "file register");
  endtask : peek

  // ==========================================================
  // scenarios
  task automatic t_zero_test;
    exec(14'h00FF);
    peek(7'h7F, 8'h00);
    exec(14'h08FF);
    state(8'h00, 1'b1);
    peek(7'h7F, 8'h00);
  endtask : t_zero_test

  task automatic t_literal;
    logic [7:0] k [3];
    k = '{8'h5A, 8'hFF, 8'h01};
    foreach (k[i]) begin
      exec({6'h30, k[i]});
      state(k[i], 1'b1);
    end
  endtask : t_literal

  task automatic t_store;
    exec(14'h304F);
    exec(14'h0080);
    state(8'h4F, 1'b1);
    peek(7'h00, 8'h4F);
  endtask : t_store

  task automatic t_move;
    exec(14'h3000);
    exec(14'h0800);
    state(8'h4F, 1'b0);
    exec(14'h3011);
    exec(14'h0880);
    state(8'h11, 1'b0);
    peek(7'h00, 8'h4F);
  endtask : t_move

  task automatic t_nop;
    exec(14'h08FF);
    exec(14'h0000);
    exec(14'h0060);
    exec(14'h0700, 1'b1);
    state(8'h11, 1'b1);
    peek(7'h00, 8'h4F);
  endtask : t_nop

  task automatic t_b2b;
    int base;
    base        = n_ret;
    instr_valid = 1'b1;
    instr_word  = 14'h08FF;
    @(posedge sys_clk) #1;
    instr_word  = 14'h303C;
    @(posedge sys_clk) #1;
    instr_word  = 14'h0090;
    @(posedge sys_clk) #1;
    instr_word  = 14'h0810;
    @(posedge sys_clk) #1;
    instr_valid = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(8'(n_ret - base), 8'h04, "retire count");
    state(8'h3C, 1'b0);
    peek(7'h10, 8'h3C);
  endtask : t_b2b

  // ==========================================================
  // closing report
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    state(8'h00, 1'b0);
    t_zero_test();
    t_literal();
    t_store();
    t_move();
    t_nop();
    t_b2b();
    end_sim();
  end
endmodule : tb_top
